// File: rtl/pesu_pkg.sv
// package for the precise event sampling unit: register map, fields, event codes
package pesu_pkg;
  // register byte offsets (all chosen, one aligned word each)
  localparam logic [7:0] OFF_ENABLE_LO = 8'h00;
  localparam logic [7:0] OFF_ENABLE_HI = 8'h04;
  localparam logic [7:0] OFF_SEL0 = 8'h10;
  localparam logic [7:0] OFF_CNT0 = 8'h20;
  localparam logic [7:0] OFF_OVF_STATUS = 8'h30;
  localparam logic [7:0] OFF_OVF_CLEAR = 8'h34;
  localparam logic [7:0] OFF_INT_STATUS = 8'h38;
  localparam logic [7:0] OFF_INT_MASK = 8'h3C;
  localparam logic [7:0] OFF_REC_COUNT = 8'h40;

  localparam int NUM_CTR = 8;
  localparam int NUM_SAMPLE_CTR = 4;
  localparam int STORE_CTR = 3;
  localparam int DIST_CTR = 1;
  // bit 63 of the 64-bit enable register is bit 31 of its high word
  localparam int STORE_EN_BIT = 31;
  localparam int LAT_EN_BASE = 0;

  // event selector fields
  localparam int SEL_EVENT_LSB = 0;
  localparam int SEL_UMASK_LSB = 8;
  localparam int SEL_EDGE_BIT = 18;
  localparam int SEL_ANY_THREAD_BIT = 21;
  localparam int SEL_EN_BIT = 22;
  localparam int SEL_INVERT_BIT = 23;
  localparam int SEL_COUNTER_MASK_FIELD_LSB = 24;

  localparam logic [7:0] EV_INSTR_RETIRED = 8'hC0;
  localparam logic [7:0] EV_MICRO_OPS_RETIRED_EVENT = 8'hC2;
  localparam logic [7:0] EV_BRANCHES = 8'hC4;
  localparam logic [7:0] EV_MISP_BRANCHES = 8'hC5;
  localparam logic [7:0] EV_MEM_UOPS = 8'hD0;
  localparam logic [7:0] EV_LOAD_SOURCE = 8'hD1;
  localparam logic [7:0] EV_LLC_SNOOP = 8'hD2;
  localparam logic [7:0] EV_MEM_TRANS = 8'hCD;
  localparam logic [7:0] UM_PRECISE_DISTRIBUTION_SUBEVENT = 8'h01;

  // record field offsets
  localparam logic [7:0] REC_OFF_ADDR = 8'h98;
  localparam logic [7:0] REC_OFF_SOURCE = 8'hA0;
  localparam logic [7:0] REC_OFF_LATENCY = 8'hA8;

  // instruction address skid
  localparam logic [1:0] SKID_PLAIN = 2'h1;
  localparam logic [1:0] SKID_FUSED = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [63:0] ip;
    logic [63:0] linear_addr;
    logic [63:0] source_status;
    logic [63:0] latency;
    logic [2:0] counter;
    logic store_mode;
  } pesu_record_type;

  typedef struct packed {
    logic retire;
    logic fused;
    logic [63:0] ip;
    logic is_store;
    logic [63:0] linear_addr;
    logic [5:0] mem_info;
    logic [15:0] load_latency;
  } pesu_retire_type;
endpackage

// File: rtl/pesu_top.sv
// precise event sampling unit: counters, arming, record build, AXI4-Lite registers
// Operation
// R1: only counters 0-3 may produce sample records
// R2: bit 63 enables store capture on counter 3
// R3: precise distribution subevent only on counter 1
// R4: captured address trails one, two when fused
// R5: selector qualifiers must be zero for sampling
// R6: reprogram sampling counters only while disabled
// R7: software writes enables at start, clears after
// R8: record offset 98H holds load/store linear address
// R9: offset A0H holds data source or store status
// R10: offset A8H latency, or zero for stores
// R11: clear overflow only of overflowed, enabled counters
// R12: accept C2H, C4H, C5H events with masks
// R13: accept D1H, D2H memory events with masks
// R14: overflow arms; next event writes the record
// R15: low enable bits select sampling counters
// R16: record mode follows overflowing counter's facility
`timescale 1ns/1ps
`default_nettype none
module pesu_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core events: one event pulse per counter plus retirement info
  input wire logic [7:0] event_hit,
  input wire pesu_pkg::pesu_retire_type retire_info,
  // sample record stream
  output pesu_pkg::pesu_record_type record,
  output logic record_valid,
  // interrupt
  output logic irq
);
  localparam int N = pesu_pkg::NUM_CTR;

  logic [31:0] enable_lo, next_enable_lo;
  logic [31:0] enable_hi, next_enable_hi;
  logic [31:0] sel [N], next_sel [N];
  logic [31:0] cnt [N], next_cnt [N];
  logic [N-1:0] ovf, next_ovf;
  logic [3:0] armed, next_armed;
  logic [1:0] int_status, next_int_status;
  logic [1:0] int_mask, next_int_mask;
  logic [31:0] rec_count, next_rec_count;
  logic [63:0] prev_ip, next_prev_ip;
  logic [63:0] prev2_ip, next_prev2_ip;
  pesu_pkg::pesu_record_type next_record;
  logic next_record_valid;
  logic next_irq;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // selector qualifies for sampling on counter idx
  function automatic logic sel_ok(input logic [31:0] s, input int idx);
    logic [7:0] ev;
    logic [7:0] um;
    logic clean;
    logic ev_ok;
    ev = s[pesu_pkg::SEL_EVENT_LSB +: 8];
    um = s[pesu_pkg::SEL_UMASK_LSB +: 8];
    clean = !s[pesu_pkg::SEL_ANY_THREAD_BIT] && !s[pesu_pkg::SEL_EDGE_BIT]
      && !s[pesu_pkg::SEL_INVERT_BIT] && s[pesu_pkg::SEL_COUNTER_MASK_FIELD_LSB +: 8] == 8'h00; // see R5
    unique case (ev)
      pesu_pkg::EV_INSTR_RETIRED:
        ev_ok = (um == pesu_pkg::UM_PRECISE_DISTRIBUTION_SUBEVENT) && (idx == pesu_pkg::DIST_CTR); // see R3
      pesu_pkg::EV_MICRO_OPS_RETIRED_EVENT: ev_ok = um inside {8'h01, 8'h02}; // see R12
      pesu_pkg::EV_BRANCHES: ev_ok = um inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h20}; // see R12
      pesu_pkg::EV_MISP_BRANCHES: ev_ok = um inside {8'h01, 8'h02, 8'h04, 8'h10, 8'h20};
      pesu_pkg::EV_MEM_UOPS:
        ev_ok = um inside {8'h11, 8'h12, 8'h21, 8'h41, 8'h42, 8'h81, 8'h82};
      pesu_pkg::EV_LOAD_SOURCE: ev_ok = um inside {8'h01, 8'h02, 8'h04, 8'h40}; // see R13
      pesu_pkg::EV_LLC_SNOOP: ev_ok = um inside {8'h01, 8'h02, 8'h04, 8'h08}; // see R13
      pesu_pkg::EV_MEM_TRANS: ev_ok = 1'b1;
      default: ev_ok = 1'b0;
    endcase
    return clean && ev_ok;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic do_write;
    logic [7:0] wa;
    logic fired;
    logic [2:0] fire_idx;
    logic [N-1:0] clr_mask;
    logic [N-1:0] ovf_set;
    logic [7:0] ra;
    do_write = 1'b0;
    wa = 8'h00;
    fired = 1'b0;
    fire_idx = 3'h0;
    clr_mask = '0;
    ovf_set = '0;
    ra = s_axi_araddr;
    next_enable_lo = enable_lo;
    next_enable_hi = enable_hi;
    next_sel = sel;
    next_cnt = cnt;
    next_ovf = ovf;
    next_armed = armed;
    next_int_status = int_status;
    next_int_mask = int_mask;
    next_rec_count = rec_count;
    next_prev_ip = prev_ip;
    next_prev2_ip = prev2_ip;
    next_record = record;
    next_record_valid = 1'b0;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;

    // retire address history for the skid
    if (retire_info.retire) begin
      next_prev_ip = retire_info.ip;
      next_prev2_ip = prev_ip;
    end

    // counting and sampling; only the first firing counter is taken per cycle
    for (int i = 0; i < N; i++) begin
      if (sel[i][pesu_pkg::SEL_EN_BIT] && event_hit[i]) begin
        next_cnt[i] = cnt[i] + 32'h1;
        if (cnt[i] == 32'hFFFFFFFF) begin
          next_ovf[i] = 1'b1;
          ovf_set[i] = 1'b1;
          if (i < pesu_pkg::NUM_SAMPLE_CTR && enable_lo[i] && sel_ok(sel[i], i)) begin
            next_armed[2'(i)] = 1'b1; // see R14 R15 R1
          end
        end else if (i < pesu_pkg::NUM_SAMPLE_CTR && armed[2'(i)] && !fired) begin
          fired = 1'b1; // see R14
          fire_idx = 3'(i);
          next_armed[2'(i)] = 1'b0;
        end
      end
    end

    if (fired) begin
      next_record_valid = 1'b1;
      next_record.counter = fire_idx;
      next_record.ip = retire_info.fused ? prev2_ip : prev_ip; // see R4
      next_record.linear_addr = retire_info.linear_addr; // see R8
      next_record.store_mode = (fire_idx == 3'(pesu_pkg::STORE_CTR))
        && enable_hi[pesu_pkg::STORE_EN_BIT]; // see R2 R16
      if (next_record.store_mode) begin
        next_record.source_status = {58'h0, retire_info.mem_info}; // see R9
        next_record.latency = 64'h0; // see R10
      end else begin
        next_record.source_status = {58'h0, retire_info.mem_info}; // see R9
        next_record.latency = {48'h0, retire_info.load_latency}; // see R10
      end
      for (int i = 0; i < pesu_pkg::NUM_SAMPLE_CTR; i++) begin
        clr_mask[i] = ovf[i] && enable_lo[i]; // see R11
      end
      next_ovf = next_ovf & ~clr_mask; // see R11
      next_rec_count = rec_count + 32'h1;
      next_int_status[0] = 1'b1;
    end
    if (|ovf_set) begin
      next_int_status[1] = 1'b1;
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    next_awready = !next_aw_held && !s_axi_bvalid && !s_axi_awready;
    next_wready = !next_w_held && !s_axi_bvalid && !s_axi_wready;
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write = 1'b1;
      wa = aw_addr;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = pesu_pkg::RESP_OKAY;
    end
    if (do_write) begin
      unique case (wa) inside
        pesu_pkg::OFF_ENABLE_LO: next_enable_lo = merge(enable_lo, w_data, w_strb) & 32'h0000000F;
        pesu_pkg::OFF_ENABLE_HI: next_enable_hi = merge(enable_hi, w_data, w_strb) & 32'h80000000;
        pesu_pkg::OFF_OVF_CLEAR: next_ovf = (next_ovf & ~w_data[N-1:0]) | ovf_set;
        pesu_pkg::OFF_INT_STATUS: next_int_status = next_int_status & ~w_data[1:0];
        pesu_pkg::OFF_INT_MASK: next_int_mask = w_data[1:0];
        [8'h10:8'h1C]: next_sel[wa[3:2]] = merge(sel[wa[3:2]], w_data, w_strb);
        [8'h20:8'h2C]: next_cnt[wa[3:2]] = merge(cnt[wa[3:2]], w_data, w_strb);
        default: next_bresp = pesu_pkg::RESP_SLVERR;
      endcase
      // set wins over clear on the interrupt status
      if (fired) begin
        next_int_status[0] = 1'b1;
      end
      if (|ovf_set) begin
        next_int_status[1] = 1'b1;
      end
    end

    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = pesu_pkg::RESP_OKAY;
      next_rdata = 32'h0;
      if (ra == pesu_pkg::OFF_ENABLE_LO) next_rdata = enable_lo;
      else if (ra == pesu_pkg::OFF_ENABLE_HI) next_rdata = enable_hi;
      else if (ra >= pesu_pkg::OFF_SEL0 && ra < pesu_pkg::OFF_CNT0) next_rdata = sel[ra[3:2]];
      else if (ra >= pesu_pkg::OFF_CNT0 && ra < pesu_pkg::OFF_OVF_STATUS)
        next_rdata = cnt[ra[3:2]];
      else if (ra == pesu_pkg::OFF_OVF_STATUS) next_rdata = {24'h0, ovf};
      else if (ra == pesu_pkg::OFF_INT_STATUS) next_rdata = {30'h0, int_status};
      else if (ra == pesu_pkg::OFF_INT_MASK) next_rdata = {30'h0, int_mask};
      else if (ra == pesu_pkg::OFF_REC_COUNT) next_rdata = rec_count;
      else if (ra != pesu_pkg::OFF_OVF_CLEAR) next_rresp = pesu_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0 :
      (!next_rvalid && !s_axi_arready);
    next_irq = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_lo <= 32'h0;
      enable_hi <= 32'h0;
      for (int i = 0; i < N; i++) begin
        sel[i] <= 32'h0;
        cnt[i] <= 32'h0;
      end
      ovf <= '0;
      armed <= 4'h0;
      int_status <= 2'h0;
      int_mask <= 2'h0;
      rec_count <= 32'h0;
      prev_ip <= 64'h0;
      prev2_ip <= 64'h0;
      record <= '0;
      record_valid <= 1'b0;
      irq <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      enable_lo <= next_enable_lo;
      enable_hi <= next_enable_hi;
      sel <= next_sel;
      cnt <= next_cnt;
      ovf <= next_ovf;
      armed <= next_armed;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      rec_count <= next_rec_count;
      prev_ip <= next_prev_ip;
      prev2_ip <= next_prev2_ip;
      record <= next_record;
      record_valid <= next_record_valid;
      irq <= next_irq;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// File: verif/pesu_top_checker.sv
// checker for the sampling unit ports, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module pesu_top_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // events and records
  input wire logic [7:0] event_hit,
  input wire pesu_pkg::pesu_record_type record,
  input wire logic record_valid,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rec_ctr;
    record_valid |-> record.counter < 3'h4;
  endproperty
  a_rec_ctr: assert property (p_rec_ctr) else $error("record from counter above 3");
  property p_store_ctr;
    record_valid && record.store_mode |-> record.counter == 3'h3;
  endproperty
  a_store_ctr: assert property (p_store_ctr) else $error("store record off counter 3");
  property p_store_lat;
    record_valid && record.store_mode |-> record.latency == 64'h0;
  endproperty
  a_store_lat: assert property (p_store_lat) else $error("store latency not zero");
  property p_rec_cause;
    record_valid |-> $past(|event_hit[3:0]);
  endproperty
  a_rec_cause: assert property (p_rec_cause) else $error("record without event");
  property p_rec_hold;
    !record_valid |-> $stable(record);
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("record changed without valid");
  property p_pend;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_pend: assert property (p_pend) else $error("ready while response pending");
  property p_ar_r;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_r: assert property (p_ar_r) else $error("read answer late");
  // no disable here: this one looks at the reset itself
  property p_rst;
    disable iff (1'b0) !aresetn |=> !record_valid && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  c_store: cover property (record_valid && record.store_mode);
  c_dist: cover property (record_valid && record.counter == 3'h1);
  c_irq: cover property ($rose(irq));
endmodule
bind pesu_top pesu_top_checker pesu_top_checker_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .event_hit(event_hit),
  .record(record),
  .record_valid(record_valid),
  .irq(irq)
);
`default_nettype wire

// File: verif/tb_pesu_top.sv
// self-checking bench for the precise event sampling unit
`timescale 1ns/1ps
`default_nettype none
module tb_pesu_top;
  typedef struct packed {
    logic [1:0] c;
    logic [31:0] sel;
    logic [3:0] en;
    logic st;
    logic rec;
    logic sm;
  } pesu_row_type;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [7:0] event_hit = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic record_valid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pesu_pkg::pesu_retire_type retire_info = '0;
  pesu_pkg::pesu_record_type record, got;
  int error_cnt = 0;
  int total_checks = 0;
  int nrec = 0;
  logic [31:0] d;
  logic [1:0] rsp;
  pesu_row_type rows [16] = '{
    '{2'h0, 32'h004001C2, 4'h1, 1'b0, 1'b1, 1'b0}, '{2'h0, 32'h004002C2, 4'h1, 1'b0, 1'b1, 1'b0},
    '{2'h2, 32'h004004C4, 4'h4, 1'b0, 1'b1, 1'b0}, '{2'h1, 32'h004010C5, 4'h2, 1'b0, 1'b1, 1'b0},
    '{2'h0, 32'h004040D1, 4'h1, 1'b0, 1'b1, 1'b0}, '{2'h3, 32'h004008D2, 4'h8, 1'b0, 1'b1, 1'b0},
    '{2'h3, 32'h004082D0, 4'h8, 1'b1, 1'b1, 1'b1}, '{2'h2, 32'h004081D0, 4'h4, 1'b1, 1'b1, 1'b0},
    '{2'h1, 32'h004001C0, 4'h2, 1'b0, 1'b1, 1'b0}, '{2'h0, 32'h004001C0, 4'h1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 32'h004401C2, 4'h1, 1'b0, 1'b0, 1'b0}, '{2'h0, 32'h006001C2, 4'h1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 32'h00C001C2, 4'h1, 1'b0, 1'b0, 1'b0}, '{2'h0, 32'h014001C2, 4'h1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 32'h004001C2, 4'h0, 1'b0, 1'b0, 1'b0}, '{2'h3, 32'h004001C2, 4'h1, 1'b0, 1'b0, 1'b0}};

  pesu_top pesu_top_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .event_hit(event_hit),
    .retire_info(retire_info),
    .record(record),
    .record_valid(record_valid),
    .irq(irq)
  );

  always #10 aclk = ~aclk;

  // values seen at the edge are the pre-edge ones, so a one-cycle pulse is caught
  always @(posedge aclk) begin
    if (record_valid) begin
      nrec++;
      got = record;
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    // ready raised only here, so back-to-back calls never drive it twice in one step
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] m);
    event_hit <= m;
    @(posedge aclk);
    event_hit <= 8'h00;
    repeat (3) @(posedge aclk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    // the tests need under 2,000 cycles; the limit allows 10,000
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    retire_info.retire = 1'b1;
    retire_info.ip = 64'h0000_7F00_0000_1000;
    retire_info.linear_addr = 64'h0000_7FFE_1234_5678;
    retire_info.mem_info = 6'h31;
    retire_info.load_latency = 16'h0123;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 16; i++) begin
      // count value first, enabling selector after it, so nothing counts mid-setup
      wr(pesu_pkg::OFF_CNT0 + {4'h0, rows[i].c, 2'h0}, 32'hFFFFFFFF);
      wr(pesu_pkg::OFF_SEL0 + {4'h0, rows[i].c, 2'h0}, rows[i].sel);
      wr(pesu_pkg::OFF_ENABLE_HI, {rows[i].st, 31'h0});
      wr(pesu_pkg::OFF_ENABLE_LO, {28'h0, rows[i].en});
      retire_info.is_store <= rows[i].sm;
      nrec = 0;
      // first event overflows and arms, second one samples
      pulse(8'h01 << rows[i].c);
      pulse(8'h01 << rows[i].c);
      chk("record count", {63'h0, rows[i].rec}, 64'(nrec));
      if (rows[i].rec) begin
        chk("counter", {62'h0, rows[i].c}, {61'h0, got.counter});
        chk("store mode", {63'h0, rows[i].sm}, {63'h0, got.store_mode});
        chk("address", retire_info.linear_addr, got.linear_addr);
        chk("ip", retire_info.ip, got.ip);
        chk("source", {58'h0, retire_info.mem_info}, got.source_status);
        chk("latency", rows[i].sm ? 64'h0 : {48'h0, retire_info.load_latency}, got.latency);
        rd(pesu_pkg::OFF_OVF_STATUS);
        chk("overflow", 64'h0, {32'h0, d});
      end
      wr(pesu_pkg::OFF_SEL0 + {4'h0, rows[i].c, 2'h0}, 32'h0);
      wr(pesu_pkg::OFF_ENABLE_LO, 32'h0);
      wr(pesu_pkg::OFF_OVF_CLEAR, 32'hFF);
      wr(pesu_pkg::OFF_INT_STATUS, 32'h3);
      $display("row %0d done", i);
    end
    // two counters overflow, only the sampling one is cleared
    wr(pesu_pkg::OFF_INT_MASK, 32'h1);
    wr(pesu_pkg::OFF_SEL0, 32'h004001C2);
    wr(pesu_pkg::OFF_SEL0 + 8'h08, 32'h004004C4);
    wr(pesu_pkg::OFF_CNT0, 32'hFFFFFFFF);
    wr(pesu_pkg::OFF_CNT0 + 8'h08, 32'hFFFFFFFF);
    wr(pesu_pkg::OFF_ENABLE_LO, 32'h1);
    nrec = 0;
    pulse(8'h05);
    pulse(8'h01);
    pulse(8'h01);
    chk("disarmed after record", 64'h1, 64'(nrec));
    rd(pesu_pkg::OFF_OVF_STATUS);
    chk("overflow kept", 64'h4, {32'h0, d});
    chk("irq set", 64'h1, {63'h0, irq});
    wr(pesu_pkg::OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 64'h0, {63'h0, irq});
    wr(pesu_pkg::OFF_INT_MASK, 32'h1);
    wr(pesu_pkg::OFF_INT_STATUS, 32'h3);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 64'h0, {63'h0, irq});
    $display("overflow and interrupt test done");
    rd(8'h80);
    chk("unmapped read", {62'h0, pesu_pkg::RESP_SLVERR}, {62'h0, rsp});
    wr(8'h84, 32'h1);
    chk("unmapped write", {62'h0, pesu_pkg::RESP_SLVERR}, {62'h0, rsp});
    $display("unmapped test done");
    // fused retire: the record carries the address two retirements back
    wr(pesu_pkg::OFF_SEL0, 32'h0);
    wr(pesu_pkg::OFF_CNT0, 32'hFFFFFFFF);
    wr(pesu_pkg::OFF_SEL0, 32'h004001C2);
    pulse(8'h01);
    retire_info.ip <= 64'h0000_7F00_0000_2000;
    @(posedge aclk);
    retire_info.ip <= 64'h0000_7F00_0000_3000;
    retire_info.fused <= 1'b1;
    nrec = 0;
    pulse(8'h01);
    retire_info.fused <= 1'b0;
    chk("fused record count", 64'h1, 64'(nrec));
    chk("fused ip", 64'h0000_7F00_0000_1000, got.ip);
    $display("fused skid test done");
    // nine table records, the two-counter one and the fused one
    rd(pesu_pkg::OFF_REC_COUNT);
    chk("record total", 64'hB, {32'h0, d});
    chk("read response", {62'h0, pesu_pkg::RESP_OKAY}, {62'h0, rsp});
    // mid-run reset: state and outputs return to idle
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("irq after reset", 64'h0, {63'h0, irq});
    rd(pesu_pkg::OFF_REC_COUNT);
    chk("record total after reset", 64'h0, {32'h0, d});
    rd(pesu_pkg::OFF_OVF_STATUS);
    chk("overflow after reset", 64'h0, {32'h0, d});
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
